// [hdl/sacc_top.v]
/*
 Simultaneous conversion control: trigger edge detect, busy flag, range
 selection in hardware or software mode, reference select, result readout.
 Assumes all pins are synchronous to clk; the analog inputs arrive as
 eight signed 16-bit words referred to the widest range.
*/
`timescale 1ns/100ps
`default_nettype none
`include "sacc_defs.vh"

module sacc_top (
  input wire clk,
  input wire arst_n,
  input wire sample_trigger,
  input wire [2:0] oversample_ratio_pins,
  input wire range_pin,
  input wire ref_select,
  input wire [127:0] analog_in,
  input wire [2:0] rd_ch,
  input wire reg_wr,
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg busy_r,
  output reg acquire_r,
  output reg sw_mode_r,
  output reg int_ref_en_r,
  output reg [15:0] live_range_r,
  output reg ext_clk_mode_r,
  output reg [15:0] result_r,
  output reg [7:0] reg_rdata_r
);

  reg rst_s1_r;
  reg rst_n_r;
  reg trig_d_r;
  reg ref_captured_r;
  reg [7:0] range_cfg_r [0:3];
  reg [15:0] latched_range_r;
  reg [127:0] sample_r;
  wire trig_rise;
  wire eng_done;
  wire [127:0] eng_codes;
  wire [15:0] mem_rd;
  wire sw_mode;
  reg [15:0] range_sel;
  integer k;
  integer j;
  wire [3:0] cfg_idx;

  // Reset release through two flops
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  assign trig_rise = sample_trigger & ~trig_d_r;
  assign sw_mode = (oversample_ratio_pins == `SACC_SW_MODE_PATTERN);

  // Register index; only the low two bits matter once the address is in range
  assign cfg_idx = reg_addr - `SACC_ADDR_RANGE_CFG_0;

  // Map a config nibble to a range code
  function [1:0] sacc_range_code;
    input [3:0] nib;
    begin
      case (nib[1:0])
        2'h0: sacc_range_code = `SACC_RANGE_2P5;
        2'h1: sacc_range_code = `SACC_RANGE_5;
        default: sacc_range_code = `SACC_RANGE_10;
      endcase
    end
  endfunction

  // Current per-channel range: pin in hardware mode, registers in software
  always @* begin
    range_sel = 16'h0000;
    for (k = 0; k < 8; k = k + 1) begin
      if (sw_mode) begin
        range_sel[k*2 +: 2] = sacc_range_code(range_cfg_r[k/2][(k%2)*4 +: 4]);
      end else begin
        range_sel[k*2 +: 2] = range_pin ? `SACC_RANGE_10 : `SACC_RANGE_5;
      end
    end
  end

  // Trigger edge, busy and acquisition tracking
  always @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      trig_d_r <= 1'b0;
      busy_r <= 1'b0;
      acquire_r <= 1'b0;
      sample_r <= 128'h0;
      latched_range_r <= 16'h0000;
    end else begin
      trig_d_r <= sample_trigger;
      if (trig_rise && !busy_r) begin
        busy_r <= 1'b1;
        acquire_r <= 1'b0;
        sample_r <= analog_in;
        latched_range_r <= range_sel;
      end else if (eng_done) begin
        busy_r <= 1'b0;
        acquire_r <= 1'b1;
      end
    end
  end

  // Status outputs; range follows pins or registers one clock later
  always @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sw_mode_r <= 1'b0;
      live_range_r <= 16'h0000;
      ext_clk_mode_r <= 1'b0;
    end else begin
      sw_mode_r <= sw_mode;
      live_range_r <= range_sel;
      ext_clk_mode_r <= sw_mode;
    end
  end

  // Reference mode follows ref_select on every clock from reset release
  always @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ref_captured_r <= 1'b0;
      int_ref_en_r <= 1'b0;
    end else begin
      if (!ref_captured_r) begin
        ref_captured_r <= 1'b1;
        int_ref_en_r <= ref_select;
      end else begin
        int_ref_en_r <= ref_select;
      end
    end
  end

  // Range configuration registers
  always @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      for (j = 0; j < 4; j = j + 1) begin
        range_cfg_r[j] <= `SACC_RANGE_CFG_RESET;
      end
      reg_rdata_r <= 8'h00;
    end else begin
      if (reg_wr && reg_addr >= `SACC_ADDR_RANGE_CFG_0 && reg_addr <= `SACC_ADDR_RANGE_CFG_3) begin
        range_cfg_r[cfg_idx[1:0]] <= reg_wdata;
      end
      case (reg_addr)
        `SACC_ADDR_RANGE_CFG_0: reg_rdata_r <= range_cfg_r[0];
        `SACC_ADDR_RANGE_CFG_1: reg_rdata_r <= range_cfg_r[1];
        `SACC_ADDR_RANGE_CFG_2: reg_rdata_r <= range_cfg_r[2];
        `SACC_ADDR_RANGE_CFG_3: reg_rdata_r <= range_cfg_r[3];
        default: reg_rdata_r <= 8'h00;
      endcase
    end
  end

  // Conversion engine; code step is span over 65536
  sacc_conv_engine u_eng (
    .clk(clk),
    .rst_n(rst_n_r),
    .start(trig_rise & ~busy_r),
    .sample_set(sample_r),
    .range_set(latched_range_r),
    .done_r(eng_done),
    .code_set_r(eng_codes)
  );

  // Results overwritten only at completion, so old set stays readable
  sacc_result_mem u_mem (
    .clk(clk),
    .rst_n(rst_n_r),
    .wr_en(eng_done),
    .wr_set(eng_codes),
    .rd_ch(rd_ch),
    .rd_data_r(mem_rd)
  );

  // Registered result port
  always @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      result_r <= 16'h0000;
    end else begin
      result_r <= mem_rd;
    end
  end

endmodule // sacc_top
`default_nettype wire

// [pkg/sacc_defs.vh]
/*
 Constants for the simultaneous conversion control block: register offsets,
 range codes, mode pattern and timing counts.
 Assumes inclusion by bare name from design files.
*/
`ifndef SACC_DEFS_VH
`define SACC_DEFS_VH

// Channel range configuration registers, two channels per register
`define SACC_ADDR_RANGE_CFG_0 4'h3
`define SACC_ADDR_RANGE_CFG_1 4'h4
`define SACC_ADDR_RANGE_CFG_2 4'h5
`define SACC_ADDR_RANGE_CFG_3 4'h6
`define SACC_RANGE_CFG_RESET 8'h00

// Range codes per channel nibble (low two bits used)
`define SACC_RANGE_2P5 2'h0
`define SACC_RANGE_5 2'h1
`define SACC_RANGE_10 2'h2

// Oversample pin pattern that selects software mode
`define SACC_SW_MODE_PATTERN 3'h7

// Conversion duration in ns and derived clock count (10 MHz clock)
`define SACC_CLK_PERIOD_NS 100
`define SACC_CONV_DURATION_NS 4000
`define SACC_CONV_CYCLES ((`SACC_CONV_DURATION_NS) / (`SACC_CLK_PERIOD_NS))

// Result width and channel count
`define SACC_RESULT_W 16
`define SACC_NUM_CH 8

`endif

// [hdl/sacc_result_mem.v]
/*
 Result store: eight 16-bit words, one per channel, written as a whole set.
 Assumes the controller writes a set only when a conversion completes.
*/
`timescale 1ns/100ps
`default_nettype none
`include "sacc_defs.vh"

module sacc_result_mem (
  input wire clk,
  input wire rst_n,
  input wire wr_en,
  input wire [127:0] wr_set,
  input wire [2:0] rd_ch,
  output reg [15:0] rd_data_r
);

  reg [127:0] set_r;

  // Whole set updates at once so a read never mixes two conversions
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      set_r <= 128'h0;
      rd_data_r <= 16'h0000;
    end else begin
      if (wr_en) begin
        set_r <= wr_set;
      end
      rd_data_r <= set_r[rd_ch*16 +: 16];
    end
  end

endmodule // sacc_result_mem
`default_nettype wire

// [hdl/sacc_conv_engine.v]
/*
 Conversion engine: models the on-chip oscillator timing and produces a
 twos-complement code per channel from the sampled inputs.
 Assumes a one-cycle start pulse and sampled inputs held by the caller.
*/
`timescale 1ns/100ps
`default_nettype none
`include "sacc_defs.vh"

module sacc_conv_engine (
  input wire clk,
  input wire rst_n,
  input wire start,
  input wire [127:0] sample_set,
  input wire [15:0] range_set,
  output reg done_r,
  output reg [127:0] code_set_r
);

  reg [7:0] cnt_r;
  reg run_r;
  integer i;

  // Scale a raw sample to a code for its range; narrower range saturates
  function [15:0] sacc_scale;
    input [15:0] raw;
    input [1:0] rng;
    reg [17:0] ext;
    begin
      ext = {{2{raw[15]}}, raw};
      case (rng)
        `SACC_RANGE_10: sacc_scale = raw;
        `SACC_RANGE_5: begin
          ext = ext <<< 1;
          sacc_scale = (ext[17:15] == 3'h0 || ext[17:15] == 3'h7) ? ext[15:0] :
                       (ext[17] ? 16'h8000 : 16'h7FFF);
        end
        default: begin
          ext = ext <<< 2;
          sacc_scale = (ext[17:15] == 3'h0 || ext[17:15] == 3'h7) ? ext[15:0] :
                       (ext[17] ? 16'h8000 : 16'h7FFF);
        end
      endcase
    end
  endfunction

  // Oscillator timer; all channels finish together
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 8'h00;
      run_r <= 1'b0;
      done_r <= 1'b0;
      code_set_r <= 128'h0;
    end else begin
      done_r <= 1'b0;
      if (start && !run_r) begin
        run_r <= 1'b1;
        cnt_r <= 8'h00;
      end else if (run_r) begin
        if (cnt_r == (`SACC_CONV_CYCLES - 2)) begin
          run_r <= 1'b0;
          done_r <= 1'b1;
          for (i = 0; i < 8; i = i + 1) begin
            code_set_r[i*16 +: 16] <= sacc_scale(sample_set[i*16 +: 16], range_set[i*2 +: 2]);
          end
        end else begin
          cnt_r <= cnt_r + 8'h01;
        end
      end
    end
  end

endmodule // sacc_conv_engine
`default_nettype wire

// [verification/sacc_host_model.sv]
/* Host model: pulses the conversion trigger, may poke it during busy,
   flags when a fresh set may be read. Assumes a 100 ns clk. */
`timescale 1ns/100ps
`default_nettype none
module sacc_host_model (
  input wire logic clk,
  input wire logic go,
  input wire logic poke,
  input wire logic busy_r,
  output logic sample_trigger,
  output logic set_ready
);
  // One trigger per request, plus a second pulse in busy if poke; low again before busy can end
  initial begin
    sample_trigger = 1'b0;
    set_ready = 1'b0;
    forever begin
      @(posedge clk iff go);
      #1 set_ready = 1'b0;
      sample_trigger = 1'b1;
      repeat (3) @(posedge clk);
      #1 sample_trigger = 1'b0;
      if (poke) begin
        repeat (5) @(posedge clk);
        #1 sample_trigger = 1'b1;
        @(posedge clk);
        #1 sample_trigger = 1'b0;
      end
      @(negedge busy_r);
      @(posedge clk);
      #1 set_ready = 1'b1;
    end
  end
endmodule // sacc_host_model
`default_nettype wire

// [verification/sacc_checker.sv]
/* Port checker for sacc_top, bound below. Assumes 40-cycle conversions. */
`timescale 1ns/100ps
`default_nettype none
module sacc_checker (
  input wire clk,
  input wire arst_n,
  input wire sample_trigger,
  input wire [2:0] oversample_ratio_pins,
  input wire range_pin,
  input wire ref_select,
  input wire [2:0] rd_ch,
  input wire busy_r,
  input wire acquire_r,
  input wire sw_mode_r,
  input wire int_ref_en_r,
  input wire [15:0] live_range_r,
  input wire ext_clk_mode_r,
  input wire [15:0] result_r
);
  logic [5:0] cnt_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Busy length counter, bounds checked below
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) cnt_r <= 6'h00;
    else cnt_r <= busy_r ? cnt_r + 6'h01 : 6'h00;
  end
  busy_start_a: assert property ($rose(sample_trigger) && !busy_r |=> busy_r)
    else $error("busy missed trigger");
  busy_len_a: assert property ($fell(busy_r) |-> cnt_r == 6'h28)
    else $error("busy length wrong");
  busy_max_a: assert property (busy_r |-> cnt_r < 6'h28)
    else $error("busy extended");
  acq_start_a: assert property ($fell(busy_r) |-> acquire_r)
    else $error("no acquire at busy fall");
  acq_excl_a: assert property (busy_r |-> !acquire_r)
    else $error("acquire during busy");
  result_hold_a: assert property (busy_r && $past(busy_r) && $past(busy_r, 2) &&
    $past(rd_ch, 2) == $past(rd_ch, 3) |-> $stable(result_r)) else $error("result moved in busy");
  mode_sel_a: assert property ($stable(oversample_ratio_pins)[*4] |->
    sw_mode_r == (oversample_ratio_pins == 3'h7) && ext_clk_mode_r == sw_mode_r) else $error("mode wrong");
  ref_sel_a: assert property ($stable(ref_select)[*4] |-> int_ref_en_r == ref_select)
    else $error("reference wrong");
  hw_range_a: assert property ((oversample_ratio_pins != 3'h7 && $stable(range_pin))[*4] |->
    live_range_r == (range_pin ? 16'hAAAA : 16'h5555)) else $error("hw range wrong");
  cover property ($fell(busy_r));
  cover property (sw_mode_r && $rose(busy_r));
  cover property (busy_r && $rose(sample_trigger));
endmodule // sacc_checker
bind sacc_top sacc_checker sacc_checker_inst (.clk, .arst_n, .sample_trigger, .oversample_ratio_pins,
  .range_pin, .ref_select, .rd_ch, .busy_r, .acquire_r, .sw_mode_r, .int_ref_en_r, .live_range_r,
  .ext_clk_mode_r, .result_r);
`default_nettype wire

// [verification/sacc_top_tb.sv]
/* Self-checking bench for sacc_top: hw wide, hw narrow, sw per-channel.
   Assumes the host model and the bound checker. */
`timescale 1ns/100ps
`default_nettype none
module sacc_top_tb;
  logic clk, arst_n, go, poke, set_ready, sample_trigger, range_pin, ref_select, reg_wr;
  logic [2:0] oversample_ratio_pins, rd_ch;
  logic [127:0] analog_in, held;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata_r;
  logic busy_r, acquire_r, sw_mode_r, int_ref_en_r, ext_clk_mode_r;
  logic [15:0] live_range_r, result_r, exp_rng, prev2;
  logic [31:0] seed = 32'h4B;
  int fails = 0, samples_checked = 0, cycles = 0;
  sacc_top sacc_top_inst (.clk, .arst_n, .sample_trigger, .oversample_ratio_pins, .range_pin, .ref_select,
    .analog_in, .rd_ch, .reg_wr, .reg_addr, .reg_wdata, .busy_r, .acquire_r, .sw_mode_r, .int_ref_en_r,
    .live_range_r, .ext_clk_mode_r, .result_r, .reg_rdata_r);
  sacc_host_model sacc_host_model_inst (.clk, .go, .poke, .busy_r, .sample_trigger, .set_ready);
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Range code to saturated code; narrow ranges amplify
  function logic [15:0] scale(input logic [15:0] raw, input logic [1:0] c);
    logic signed [17:0] v;
    v = $signed({{2{raw[15]}}, raw}) <<< ((c == 2'h0) ? 2 : (c == 2'h1) ? 1 : 0);
    if (v > 18'sh07FFF) return 16'h7FFF;
    if (v < 18'sh38000) return 16'h8000;
    return v[15:0];
  endfunction
  // Config byte for register r: low nibble even channel, high nibble odd channel
  function logic [7:0] cfg_byte(input int r);
    return {2'h0, exp_rng[4*r+2 +: 2], 2'h0, exp_rng[4*r +: 2]};
  endfunction
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task report_and_stop;
    $display("checked=%0d fails=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #1 reg_wr = 1'b0;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      report_and_stop();
    end
  end
  initial begin
    {arst_n, go, poke, range_pin, ref_select, reg_wr} = 6'h00;
    {oversample_ratio_pins, rd_ch, reg_addr, reg_wdata} = 18'h00000;
    analog_in = 128'h0;
    prev2 = 16'h0000;
    repeat (16) @(posedge clk);
    #1 arst_n = 1'b1;
    repeat (4) @(posedge clk);
    for (int m = 0; m < 3; m++) begin
      #1 oversample_ratio_pins = (m == 2) ? 3'h7 : 3'(xs() % 7);
      range_pin = (m == 0);
      ref_select = m[0];
      for (int k = 0; k < 8; k++) begin
        exp_rng[2*k +: 2] = (m == 0) ? 2'h2 : (m == 1) ? 2'h1 : 2'(k % 3);
        analog_in[16*k +: 16] = 16'(xs());
      end
      analog_in[31:0] = 32'h80007FFF;
      if (m == 2) for (int r = 0; r < 4; r++) wr(4'(3 + r), cfg_byte(r));
      held = analog_in;
      go = 1'b1;
      poke = (m == 0);
      @(posedge clk);
      #1 go = 1'b0;
      repeat (3) @(posedge clk);
      // Inputs move during busy; the previous set must still read back
      #1 analog_in = {4{xs()}};
      range_pin = (m == 2) ? ~range_pin : (m == 0);
      rd_ch = 3'h2;
      repeat (3) @(posedge clk);
      #1 chk(result_r, prev2);
      // Config change in mid-conversion must not reach this set
      if (m == 2) wr(4'h4, 8'h11);
      for (int i = 0; i < 100 && !set_ready; i++) @(posedge clk);
      #1 chk({15'h0000, set_ready}, 16'h0001);
      if (m == 2) wr(4'h4, cfg_byte(1));
      @(posedge clk);
      #1 chk(live_range_r, exp_rng);
      for (int k = 0; k < 8; k++) begin
        rd_ch = 3'(k);
        reg_addr = (k < 4) ? 4'(3 + k) : 4'h0;
        repeat (3) @(posedge clk);
        #1 chk(result_r, scale(held[16*k +: 16], exp_rng[2*k +: 2]));
        if (m == 2 && k < 5) chk({8'h00, reg_rdata_r}, (k < 4) ? {8'h00, cfg_byte(k)} : 16'h0000);
      end
      prev2 = scale(held[47:32], exp_rng[5:4]);
      $display("test %0d done", m);
    end
    report_and_stop();
  end
endmodule // sacc_top_tb
`default_nettype wire
